//--- verilog/rcs_sync_regs.sv
// Register block of the CPU pair synchronisation module.
//
// Behaviour
// - Pair state write sets both CPU state nibbles.
// - Mailbox read returns partner alarm bits.
// - Alarm bits read zero when partner unpowered.
// - Mailbox write forwards alarm bits to partner.
// - Mailbox bit 7 low lights fault LED.
// - Write to backup begin starts backup.
// - Write to backup end stops backup.
// - Backup writes ignore their data value.
// - Identity read tells first or second CPU.
// - Identity read fires monitor, drops lock-step.
// - Synchronous diagnostics need both switches on.
// - Single-CPU diagnostic never reaches the partner.
// - Decode address with read and write strobes.
// - Updated CPU holds acknowledge until master arrives.
`timescale 1ns/1ps
module rcs_sync_regs
  import rcs_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_n,
  // Peripheral bus
  input  wire logic [RCS_ADDR_W-1:0]  i_addr,
  input  wire logic                   i_periph_address_range,
  input  wire logic                   i_periph_read_strobe_n,
  input  wire logic                   i_periph_write_strobe_n,
  input  wire logic [RCS_DATA_W-1:0]  i_data,
  output logic      [RCS_DATA_W-1:0]  o_data,
  output logic                        o_data_oe,
  output logic                        o_periph_ack_n,
  // Partner sync_module link
  input  wire logic [RCS_ALARM_W-1:0] i_partner_alarm_bits,
  input  wire logic                   i_partner_powered,
  input  wire logic                   i_partner_at_begin,
  output logic      [RCS_ALARM_W-1:0] o_alarm_bits,
  output logic                        o_at_begin,
  // Board straps and switches
  input  wire logic                   i_cpu_second,
  input  wire logic                   i_diag_switch_local,
  input  wire logic                   i_diag_switch_partner,
  // Diagnostic_interface requests
  input  wire logic                   i_diag_req,
  input  wire logic                   i_single_cpu_diag,
  // Status and indicators
  output logic      [RCS_DATA_W-1:0]  o_pair_state,
  output logic                        o_fault_led,
  output logic                        o_backup_active,
  output logic                        o_lockstep,
  output logic                        o_discrepancy,
  output logic                        o_diag_sync,
  output logic                        o_diag_fwd,
  output logic                        o_diag_local
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [RCS_DATA_W-1:0]  pair_state;   // Written pair state.
    logic [RCS_ALARM_W-1:0] alarm_out;    // Bits sent to the partner.
    logic                   fault_led;    // Own-CPU fault indicator.
    rcs_bk_state_t          bk;           // Backup sequencer.
    logic                   bk_active;    // Sequencer is out of idle.
    logic                   lockstep;     // CPUs run in step.
    logic                   discrepancy;  // Monitor trigger pulse.
    logic [RCS_DATA_W-1:0]  rdata;        // Read data driven to bus.
    logic                   data_oe;      // Bus drive enable.
    logic                   ack_n;        // Peripheral acknowledge.
    logic                   at_begin;     // Local access at backup begin.
    logic                   cpu_second;   // Sampled identity strap.
    logic                   diag_sync;    // Diagnostics reach both CPUs.
    logic                   diag_fwd;     // Request forwarded to partner.
    logic                   diag_local;   // Request applied locally.
  } rcs_main_t;

  rcs_main_t st_r;    // Registered state.
  rcs_main_t st_nxt;  // Next state.

  // ----------------------------------------------------------------------------
  // Strobe edges and partner bits
  // ----------------------------------------------------------------------------
  logic                   rd_fall;   // Read strobe has just gone low.
  logic                   wr_fall;   // Write strobe has just gone low.
  logic [RCS_ALARM_W-1:0] rx_bits;   // Power-gated partner alarm bits.

  // Read strobe edge.
  rcs_strobe_edge #(.W(1)) u_rd_edge (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_strobe_n (i_periph_read_strobe_n),
    .o_fall     (rd_fall)
  );

  // Write strobe edge.
  rcs_strobe_edge #(.W(1)) u_wr_edge (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_strobe_n (i_periph_write_strobe_n),
    .o_fall     (wr_fall)
  );

  // Incoming mailbox bits, zero while the partner has no power.
  rcs_alarm_rx #(.W(RCS_ALARM_W)) u_rx (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_bits    (i_partner_alarm_bits),
    .i_powered (i_partner_powered),
    .o_bits    (rx_bits)
  );

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  logic hit_ps;    // Pair state address.
  logic hit_mb;    // Mailbox address.
  logic hit_bb;    // Backup begin address.
  logic hit_be;    // Backup end address.
  logic hit_id;    // Identity address.
  logic hit_any;   // Any address of this block.
  logic rd_act;    // Read access in progress.
  logic wr_act;    // Write access in progress.
  logic rd_ev;     // First cycle of a read.
  logic wr_ev;     // First cycle of a write.
  logic loc_mst;   // Local CPU is flagged master.

  // Only the range select plus an exact address match claims an access.
  assign hit_ps  = i_periph_address_range && (i_addr == RCS_ADDR_PAIR_STATE);
  assign hit_mb  = i_periph_address_range && (i_addr == RCS_ADDR_MAILBOX);
  assign hit_bb  = i_periph_address_range && (i_addr == RCS_ADDR_BK_BEGIN);
  assign hit_be  = i_periph_address_range && (i_addr == RCS_ADDR_BK_END);
  assign hit_id  = i_periph_address_range && (i_addr == RCS_ADDR_CPU_ID);
  assign hit_any = hit_ps | hit_mb | hit_bb | hit_be | hit_id;
  assign rd_act  = hit_any & ~i_periph_read_strobe_n;
  assign wr_act  = hit_any & ~i_periph_write_strobe_n;
  assign rd_ev   = hit_any & rd_fall;
  assign wr_ev   = hit_any & wr_fall;

  // Master bit of the local CPU's own nibble.
  assign loc_mst = st_r.cpu_second ? st_r.pair_state[RCS_PS_CPU2_OFS + RCS_PS_MASTER_BIT]
                                   : st_r.pair_state[RCS_PS_MASTER_BIT];

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  always_comb begin
    st_nxt             = st_r;
    st_nxt.discrepancy = 1'b0;
    st_nxt.cpu_second  = i_cpu_second;

    // Pair state write takes all eight bits as given.
    if (wr_ev && hit_ps) begin
      st_nxt.pair_state = i_data;
    end

    // Mailbox write: bit 6 is dropped, bit 7 is an active-low fault flag.
    if (wr_ev && hit_mb) begin
      st_nxt.alarm_out = i_data[RCS_ALARM_W-1:0];
      st_nxt.fault_led = ~i_data[RCS_FAULT_BIT];
    end

    // Backup sequencer; the data bus is never looked at here.
    case (st_r.bk)
      RCS_BK_IDLE: begin
        if (wr_ev && hit_bb) begin
          // The master has nothing to wait for; the updated CPU stalls.
          st_nxt.bk = loc_mst ? RCS_BK_RUN : RCS_BK_WAIT;
        end
      end
      RCS_BK_WAIT: begin
        if (i_partner_at_begin) begin
          st_nxt.bk = RCS_BK_RUN;
        end
      end
      RCS_BK_RUN: begin
        if (wr_ev && hit_be) begin
          st_nxt.bk       = RCS_BK_IDLE;
          st_nxt.lockstep = 1'b1;
        end
      end
      default: begin
        st_nxt.bk = RCS_BK_IDLE;
      end
    endcase
    // Registered copy, so the backup indicator comes straight from a flop.
    st_nxt.bk_active = (st_nxt.bk != RCS_BK_IDLE);

    // Identity read fires the discrepancy monitor and ends lock-step.
    if (rd_ev && hit_id) begin
      st_nxt.discrepancy = 1'b1;
      st_nxt.lockstep    = 1'b0;
    end

    // Read data follows the address while the read strobe is low.
    st_nxt.data_oe = rd_act;
    if (!rd_act) begin
      st_nxt.rdata = '0;
    end else if (hit_ps) begin
      st_nxt.rdata = st_r.pair_state;
    end else if (hit_mb) begin
      st_nxt.rdata = RCS_DATA_W'(rx_bits);
    end else if (hit_id) begin
      st_nxt.rdata = st_r.cpu_second ? RCS_ID_SECOND : RCS_ID_FIRST;
    end else begin
      st_nxt.rdata = '0;
    end

    // Acknowledge any claimed access, except while waiting for the master.
    st_nxt.ack_n    = ~(rd_act | wr_act) | (st_nxt.bk == RCS_BK_WAIT);
    st_nxt.at_begin = wr_act & hit_bb;

    // Differing switches leave diagnostics local only.
    st_nxt.diag_sync  = st_r.lockstep & i_diag_switch_local
                        & i_diag_switch_partner;
    // The single-CPU function is never passed on.
    st_nxt.diag_fwd   = st_nxt.diag_sync & i_diag_req & ~i_single_cpu_diag;
    st_nxt.diag_local = i_diag_req;
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  // Reset loads constants only; the strap is sampled on the following edges.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_r            <= '0;
      st_r.pair_state <= RCS_PS_RST;
      st_r.alarm_out  <= RCS_ALARM_RST;
      st_r.bk         <= RCS_BK_IDLE;
      st_r.ack_n      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign o_data          = st_r.rdata;
  assign o_data_oe       = st_r.data_oe;
  assign o_periph_ack_n  = st_r.ack_n;
  assign o_alarm_bits    = st_r.alarm_out;
  assign o_at_begin      = st_r.at_begin;
  assign o_pair_state    = st_r.pair_state;
  assign o_fault_led     = st_r.fault_led;
  assign o_backup_active = st_r.bk_active;
  assign o_lockstep      = st_r.lockstep;
  assign o_discrepancy   = st_r.discrepancy;
  assign o_diag_sync     = st_r.diag_sync;
  assign o_diag_fwd      = st_r.diag_fwd;
  assign o_diag_local    = st_r.diag_local;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_wr_bb;
    wr_ev && hit_bb;
  endsequence

  sequence s_wr_be;
    wr_ev && hit_be && (st_r.bk == RCS_BK_RUN);
  endsequence

  sequence s_rd_id;
    rd_ev && hit_id;
  endsequence

  ps_write_a: assert property (
    (wr_ev && hit_ps) |=> (o_pair_state == $past(i_data)))
    else $error("pair state not taken from write");

  mbox_read_a: assert property (
    (rd_act && hit_mb) |=> (o_data_oe && o_data[RCS_ALARM_W-1:0] == $past(rx_bits)))
    else $error("mailbox read data wrong");

  mbox_upper_a: assert property (
    (rd_act && hit_mb) |=> (o_data[RCS_DATA_W-1:RCS_ALARM_W] == '0))
    else $error("mailbox upper bits not zero");

  mbox_write_a: assert property (
    (wr_ev && hit_mb) |=> (o_alarm_bits == $past(i_data[RCS_ALARM_W-1:0])))
    else $error("alarm bits not forwarded");

  fault_led_a: assert property (
    (wr_ev && hit_mb) |=> (o_fault_led == !$past(i_data[RCS_FAULT_BIT])))
    else $error("fault led does not follow bit 7");

  bk_start_a: assert property (
    (s_wr_bb and (st_r.bk == RCS_BK_IDLE)) |=> o_backup_active)
    else $error("backup did not start");

  bk_end_a: assert property (
    s_wr_be |=> (!o_backup_active && o_lockstep))
    else $error("backup did not end");

  id_read_a: assert property (
    s_rd_id |=> (o_discrepancy && !o_lockstep) ##1 !o_discrepancy)
    else $error("identity read did not fire monitor");

  id_value_a: assert property (
    (rd_act && hit_id) |=> (o_data == ($past(st_r.cpu_second) ? RCS_ID_SECOND : RCS_ID_FIRST)))
    else $error("identity value wrong");

  ack_hold_a: assert property (
    (st_r.bk == RCS_BK_WAIT && !i_partner_at_begin) |=> o_periph_ack_n)
    else $error("acknowledge given before master arrived");

  diag_sync_a: assert property (
    o_diag_sync |-> $past(i_diag_switch_local && i_diag_switch_partner))
    else $error("sync diagnostics without both switches");

  single_diag_a: assert property (
    i_single_cpu_diag |=> !o_diag_fwd)
    else $error("single-cpu diagnostic forwarded");

  idle_bus_a: assert property (
    (i_periph_read_strobe_n && i_periph_write_strobe_n) |=> (o_periph_ack_n && !o_data_oe))
    else $error("bus answered without strobe");

endmodule : rcs_sync_regs

//--- shared/rcs_pkg.sv
// Package with addresses, field layout and reset values of the sync register block.
package rcs_pkg;

  // ----------------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------------
  localparam int RCS_ADDR_W  = 16;  // Peripheral bus address width.
  localparam int RCS_DATA_W  = 8;   // Peripheral bus data width.
  localparam int RCS_ALARM_W = 6;   // Alarm bits exchanged with the partner.

  // ----------------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------------
  localparam logic [15:0] RCS_ADDR_PAIR_STATE = 16'h8FD0;  // Pair state.
  localparam logic [15:0] RCS_ADDR_MAILBOX    = 16'h8FD1;  // Mailbox in/out.
  localparam logic [15:0] RCS_ADDR_BK_BEGIN   = 16'h8FD2;  // Backup begin.
  localparam logic [15:0] RCS_ADDR_BK_END     = 16'h8FD3;  // Backup end.
  localparam logic [15:0] RCS_ADDR_CPU_ID     = 16'h4FD1;  // CPU identity.

  // ----------------------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------------------
  localparam int RCS_PS_CPU2_OFS   = 4;  // Second CPU nibble starts here.
  localparam int RCS_PS_MASTER_BIT = 0;  // Master bit inside a nibble.
  localparam int RCS_FAULT_BIT     = 7;  // Active-low fault flag in mailbox.
  localparam logic [7:0] RCS_ID_FIRST   = 8'h01;  // Identity of first CPU.
  localparam logic [7:0] RCS_ID_SECOND  = 8'h02;  // Identity of second CPU.
  localparam logic [7:0] RCS_PS_RST     = 8'h00;  // Pair state after reset.
  localparam logic [5:0] RCS_ALARM_RST  = 6'h00;  // Alarm bits after reset.

  // ----------------------------------------------------------------------------
  // Backup sequencer states
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    RCS_BK_IDLE = 3'b001,  // No backup in progress.
    RCS_BK_WAIT = 3'b010,  // Updated CPU waits for the master to arrive.
    RCS_BK_RUN  = 3'b100   // Backup copying in progress.
  } rcs_bk_state_t;

endpackage : rcs_pkg

//--- verilog/rcs_strobe_edge.sv
// Falling-edge detector for active-low bus strobes.
`timescale 1ns/1ps
module rcs_strobe_edge
  import rcs_pkg::*;
#(
  parameter int W = 1  // Number of strobes watched.
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  // Strobes
  input  wire logic [W-1:0] i_strobe_n,
  output logic      [W-1:0] o_fall
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] prev;  // Strobe level one cycle ago.
  } rcs_edge_t;

  rcs_edge_t st_r;   // Registered state.
  rcs_edge_t st_nxt; // Next state.

  // Remember the level; idle strobes are high, so reset to ones.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = i_strobe_n;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_r.prev <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // One pulse per access, however long the strobe is held low.
  assign o_fall = st_r.prev & ~i_strobe_n;

  fall_once_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_fall[0] |=> !o_fall[0])
    else $error("strobe edge reported twice");

endmodule : rcs_strobe_edge

//--- verilog/rcs_alarm_rx.sv
// Receiver of partner alarm bits with power gating.
`timescale 1ns/1ps
module rcs_alarm_rx
  import rcs_pkg::*;
#(
  parameter int W = RCS_ALARM_W  // Alarm bit count.
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  // Partner side
  input  wire logic [W-1:0] i_bits,
  input  wire logic         i_powered,
  // Local side
  output logic      [W-1:0] o_bits
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] bits;  // Gated copy of the partner bits.
  } rcs_rx_t;

  rcs_rx_t st_r;   // Registered state.
  rcs_rx_t st_nxt; // Next state.

  // A dead partner may leave its drivers floating at any level, so the
  // bits are forced low instead of trusting the last value seen.
  always_comb begin
    st_nxt = st_r;
    if (i_powered) begin
      st_nxt.bits = i_bits;
    end else begin
      st_nxt.bits = '0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_r.bits <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_bits = st_r.bits;

  alarm_off_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_powered |=> (o_bits == '0))
    else $error("alarm bits not zero with partner unpowered");

endmodule : rcs_alarm_rx

//--- verif/rcs_twin_model.sv
// Behavioural model of the twin sync_module in the other CPU of the pair.
`timescale 1ns/1ps
module rcs_twin_model
  import rcs_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_n,
  // Commands from the bench
  input  wire logic [RCS_ALARM_W-1:0] i_bits,
  input  wire logic                   i_power,
  input  wire logic                   i_arrive,
  // Link from the local module
  input  wire logic [RCS_ALARM_W-1:0] i_local_bits,
  // Link towards the local module
  output logic      [RCS_ALARM_W-1:0] o_bits,
  output logic                        o_powered,
  output logic                        o_at_begin,
  output logic      [RCS_ALARM_W-1:0] o_seen
);
  // ----------------------------------------------------------------------------
  // Line behaviour
  // ----------------------------------------------------------------------------
  logic [RCS_ALARM_W-1:0] junk_r;  // Pattern shown by an unpowered partner.

  // A dead partner does not hold its last value; the pattern flips every cycle.
  always_ff @(posedge i_clk_sys) begin
    junk_r <= i_rst_n ? ~junk_r : 6'h15;
  end

  assign o_bits     = i_power ? i_bits : junk_r;
  assign o_powered  = i_power;
  assign o_at_begin = i_power & i_arrive;
  assign o_seen     = i_local_bits;
endmodule : rcs_twin_model

//--- verif/tb_top.sv
// Self-checking testbench of the sync register block with its twin model.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import rcs_pkg::*;
  // ----------------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------------
  logic        clk, rst_n, rng, rd_n, wr_n, t_power, t_arrive, cpu_second;
  logic        sw_l, sw_p, diag_req, single;
  logic [15:0] addr;
  logic [7:0]  wdata, o_data, o_pair_state, q;
  logic [5:0]  t_bits, p_bits, o_alarm, seen;
  logic        o_oe, ack_n, p_pow, p_beg, at_begin, led, bk, lock, disc, dsync, dfwd, dloc;
  logic        disc_seen, oe_seen;
  int          mismatches, total_checks, wait_n;

  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  rcs_sync_regs dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_periph_address_range(rng),
    .i_periph_read_strobe_n(rd_n), .i_periph_write_strobe_n(wr_n), .i_data(wdata),
    .o_data(o_data), .o_data_oe(o_oe), .o_periph_ack_n(ack_n),
    .i_partner_alarm_bits(p_bits), .i_partner_powered(p_pow), .i_partner_at_begin(p_beg),
    .o_alarm_bits(o_alarm), .o_at_begin(at_begin), .i_cpu_second(cpu_second),
    .i_diag_switch_local(sw_l), .i_diag_switch_partner(sw_p), .i_diag_req(diag_req),
    .i_single_cpu_diag(single), .o_pair_state(o_pair_state), .o_fault_led(led),
    .o_backup_active(bk), .o_lockstep(lock), .o_discrepancy(disc), .o_diag_sync(dsync),
    .o_diag_fwd(dfwd), .o_diag_local(dloc));

  rcs_twin_model u_twin (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_bits(t_bits), .i_power(t_power),
    .i_arrive(t_arrive), .i_local_bits(o_alarm), .o_bits(p_bits), .o_powered(p_pow),
    .o_at_begin(p_beg), .o_seen(seen));

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // One bus access; the strobe is held until ack is seen or the wait runs out.
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic exp_ack);
    int n;
    n = 0;
    @(negedge clk);
    addr = a;
    wdata = d;
    if (w) wr_n = 1'b0;
    else rd_n = 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ack_n !== 1'b0 && n < (exp_ack ? 30 : 5));
    wait_n = n;
    q = o_data;
    oe_seen = o_oe;
    disc_seen = disc;
    `CHK("ack", !exp_ack, ack_n)
    @(negedge clk);
    wr_n = 1'b1;
    rd_n = 1'b1;
  endtask : acc

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 1'b1);
  endtask : wr

  // Read with expected data and an enabled data driver.
  task automatic rdc(input string nm, input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, 1'b1);
    `CHK(nm, e, q)
    `CHK("read enable", 1'b1, oe_seen)
  endtask : rdc

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask : done

  // ----------------------------------------------------------------------------
  // Watchdog: the tests need well under a thousand cycles.
  // ----------------------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    end_sim();
  end

  // ----------------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------------
  initial begin
    logic [7:0] ps [4];
    ps = '{8'h01, 8'h12, 8'h48, 8'h84};
    rst_n = 1'b0; rng = 1'b1; rd_n = 1'b1; wr_n = 1'b1; addr = 16'h0000; wdata = 8'h00;
    t_bits = 6'h00; t_power = 1'b1; t_arrive = 1'b0; cpu_second = 1'b0;
    sw_l = 1'b0; sw_p = 1'b0; diag_req = 1'b0; single = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    `CHK("reset ack", 1'b1, ack_n)
    `CHK("reset lockstep", 1'b0, lock)
    `CHK("reset backup", 1'b0, bk)
    done("reset");
    // Pair state written and read back, each nibble exercised.
    foreach (ps[i]) begin
      wr(RCS_ADDR_PAIR_STATE, ps[i]);
      `CHK("pair state", ps[i], o_pair_state)
      rdc("pair read", RCS_ADDR_PAIR_STATE, ps[i]);
    end
    done("pair state");
    // Outgoing mailbox: bit 6 dropped, bit 7 drives the LED inverted.
    wr(RCS_ADDR_MAILBOX, 8'h45);
    `CHK("alarm out", 6'h05, seen)
    `CHK("fault led", 1'b1, led)
    wr(RCS_ADDR_MAILBOX, 8'hBF);
    `CHK("alarm out", 6'h3F, seen)
    `CHK("fault led", 1'b0, led)
    // Incoming mailbox, with the partner powered and then dead.
    t_bits = 6'h2A;
    rdc("mailbox", RCS_ADDR_MAILBOX, 8'h2A);
    t_power = 1'b0;
    rdc("mailbox dead", RCS_ADDR_MAILBOX, 8'h00);
    rdc("mailbox dead", RCS_ADDR_MAILBOX, 8'h00);
    t_power = 1'b1;
    t_bits = 6'h15;
    rdc("mailbox", RCS_ADDR_MAILBOX, 8'h15);
    done("mailbox");
    // Unmapped address and deselected range are refused.
    acc(1'b1, 16'h8FD4, 8'hFF, 1'b0);
    rng = 1'b0;
    acc(1'b1, RCS_ADDR_PAIR_STATE, 8'hFF, 1'b0);
    rng = 1'b1;
    `CHK("pair kept", 8'h84, o_pair_state)
    done("refused");
    // An end write with no backup running changes nothing.
    wr(RCS_ADDR_BK_END, 8'h00);
    `CHK("end when idle", 1'b0, bk)
    `CHK("end when idle lockstep", 1'b0, lock)
    // Backup as master: prompt ack, data ignored.
    wr(RCS_ADDR_PAIR_STATE, 8'h01);
    wr(RCS_ADDR_BK_BEGIN, 8'hA5);
    `CHK("begin ack delay", 1, wait_n)
    `CHK("backup on", 1'b1, bk)
    wr(RCS_ADDR_BK_END, 8'h3C);
    `CHK("backup off", 1'b0, bk)
    `CHK("lockstep", 1'b1, lock)
    done("backup master");
    // Diagnostics in step: both switches on, then the single-CPU function.
    sw_l = 1'b1; sw_p = 1'b1; diag_req = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("diag sync", 1'b1, dsync)
    `CHK("diag fwd", 1'b1, dfwd)
    single = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("single fwd", 1'b0, dfwd)
    `CHK("single local", 1'b1, dloc)
    single = 1'b0; sw_p = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("switch mismatch", 1'b0, dsync)
    `CHK("switch mismatch fwd", 1'b0, dfwd)
    diag_req = 1'b0;
    done("diag");
    // Identity read fires the monitor and drops lock-step.
    rdc("identity", RCS_ADDR_CPU_ID, RCS_ID_FIRST);
    `CHK("monitor pulse", 1'b1, disc_seen)
    `CHK("lockstep dropped", 1'b0, lock)
    // The pulse stands one full cycle, so look only after the next edge.
    @(negedge clk);
    `CHK("monitor ends", 1'b0, disc)
    cpu_second = 1'b1;
    rdc("identity", RCS_ADDR_CPU_ID, RCS_ID_SECOND);
    done("identity");
    // Backup on the updated CPU: ack withheld until the master arrives.
    fork
      acc(1'b1, RCS_ADDR_BK_BEGIN, 8'h00, 1'b1);
      begin
        repeat (6) @(negedge clk);
        `CHK("at begin", 1'b1, at_begin)
        `CHK("ack held", 1'b1, ack_n)
        t_arrive = 1'b1;
      end
    join
    t_arrive = 1'b0;
    `CHK("held wait", 1'b1, wait_n > 5)
    `CHK("backup on", 1'b1, bk)
    wr(RCS_ADDR_BK_END, 8'h00);
    `CHK("lockstep", 1'b1, lock)
    done("backup updated");
    end_sim();
  end
endmodule : tb_top
